// File: valve_io_pkg.sv
package valve_io_pkg;

  // clock and timing
  localparam int unsigned CLK_HZ        = 10_000_000;
  localparam int unsigned FILTER_MS     = 10;
  localparam int unsigned FILTER_CYCLES = (FILTER_MS * CLK_HZ + 999) / 1000;
  localparam int unsigned WDOG_LED_MS   = 100;
  localparam int unsigned WDOG_CYCLES   = (WDOG_LED_MS * CLK_HZ) / 1000;

  // register byte offsets
  localparam logic [4:0] OFS_OUT_LATCH = 5'h00;
  localparam logic [4:0] OFS_IN_LOW    = 5'h04;
  localparam logic [4:0] OFS_IN_HIGH   = 5'h08;
  localparam logic [4:0] OFS_EXCITE    = 5'h0c;
  localparam logic [4:0] OFS_STATUS    = 5'h10;

  // output latch fields
  localparam int unsigned OUT_CH0     = 0;
  localparam int unsigned OUT_CH1     = 1;
  localparam logic [1:0]  OUT_RESET   = 2'h0;

  // high input byte fields
  localparam int unsigned HI_FIELD9   = 0;
  localparam int unsigned HI_READY0   = 3;
  localparam int unsigned HI_POWER0   = 5;
  localparam int unsigned HI_SEALIN0  = 7;
  localparam int unsigned HI_WIDTH    = 9;

  // status register fields
  localparam int unsigned ST_NMI      = 0;
  localparam int unsigned ST_JUMPER   = 1;

  // filter lane map
  localparam int unsigned F_FIELD     = 0;
  localparam int unsigned F_READY     = 11;
  localparam int unsigned F_POWER     = 13;
  localparam int unsigned F_SEALV     = 15;
  localparam int unsigned F_SWITCH    = 17;
  localparam int unsigned F_EXCITE    = 19;
  localparam int unsigned F_WIDTH     = 22;
  localparam logic [21:0] F_INIT      = 22'h39ffff;

  localparam int unsigned FIELD_COUNT = 11;
  localparam int unsigned LED_COUNT   = 12;

endpackage : valve_io_pkg

// File: pulse_reject_filter.sv
`timescale 1ns/1ps
`default_nettype none

module pulse_reject_filter #(
  parameter int unsigned        WIDTH = 22,
  parameter int unsigned        HOLD  = 100000,
  parameter logic [WIDTH-1:0]   INIT  = '1
) (
  input  wire logic             clk,
  input  wire logic             nrst,
  input  wire logic [WIDTH-1:0] raw,
  output logic      [WIDTH-1:0] clean
);

  localparam int unsigned CW = $clog2(HOLD + 1);

  typedef struct packed {
    logic [WIDTH-1:0]         sync1;
    logic [WIDTH-1:0]         sync2;
    logic [WIDTH-1:0]         sync3;
    logic [WIDTH-1:0]         stable;
    logic [WIDTH-1:0][CW-1:0] cnt;
  } filt_t;

  filt_t filt_reg;
  filt_t filt_next;
  logic  any_full;

  always_comb
  begin
    filt_next    = filt_reg;
    any_full     = 1'b0;
    filt_next.sync1 = raw;
    filt_next.sync2 = filt_reg.sync1;
    filt_next.sync3 = filt_reg.sync2;
    for (int i = 0; i < WIDTH; i++)
    begin
      if (filt_reg.sync2[i] == filt_reg.sync3[i] && filt_reg.sync3[i] != filt_reg.stable[i])
      begin
        if (filt_reg.cnt[i] == CW'(HOLD - 1))
        begin
          filt_next.stable[i] = filt_reg.sync3[i];
          filt_next.cnt[i]    = '0;
          any_full            = 1'b1;
        end
        else
        begin
          filt_next.cnt[i] = filt_reg.cnt[i] + 1'b1;
        end
      end
      else
      begin
        filt_next.cnt[i] = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      filt_reg        <= '0;
      filt_reg.sync1  <= INIT;
      filt_reg.sync2  <= INIT;
      filt_reg.sync3  <= INIT;
      filt_reg.stable <= INIT;
    end
    else
    begin
      filt_reg <= filt_next;
    end
  end

  assign clean = filt_reg.stable;

  a_filter_settle : assert property (@(posedge clk) disable iff (!nrst)
    (clean != $past(clean)) |-> $past(any_full))
    else $error("filtered level changed before hold time");

endmodule : pulse_reject_filter

`default_nettype wire

// File: valve_io_board_ports.sv
`timescale 1ns/1ps
`default_nettype none

module valve_io_board_ports #(
  parameter int unsigned FILTER_CYCLES = valve_io_pkg::FILTER_CYCLES,
  parameter int unsigned WDOG_CYCLES   = valve_io_pkg::WDOG_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [4:0]  address,
  input  wire logic        read,
  input  wire logic        write,
  input  wire logic [3:0]  byteenable,
  input  wire logic [31:0] writedata,
  output logic      [31:0] readdata,
  output logic             waitrequest,
  input  wire logic [10:0] field_input_n,
  input  wire logic        chan0_ready_n,
  input  wire logic        chan1_ready_n,
  input  wire logic        chan0_power_ok_n,
  input  wire logic        chan1_power_ok_n,
  input  wire logic        chan0_sealin_volt_n,
  input  wire logic        chan1_sealin_volt_n,
  input  wire logic        sealin_switch_a,
  input  wire logic        sealin_switch_b,
  input  wire logic        excite_sense_a_n,
  input  wire logic        excite_sense_b_n,
  input  wire logic        excite_sense_c_n,
  input  wire logic        calib_jumper,
  input  wire logic        rx_select_port_a,
  input  wire logic        intercomm_tx_busy,
  input  wire logic        intercomm_rx_busy,
  input  wire logic        watchdog_kick,
  output logic      [1:0]  relay_enable,
  output logic             nmi,
  output logic             serial_port_select_led,
  output logic             tx_led,
  output logic             rx_led,
  output logic             watchdog_kick_led,
  output logic      [1:0]  chan_ready_led,
  output logic      [1:0]  power_led,
  output logic      [1:0]  sealin_led,
  output logic      [1:0]  chan_out_led,
  output logic      [11:0] input_led
);

  localparam int unsigned WCW = $clog2(WDOG_CYCLES + 1);

  typedef struct packed {
    logic            jmp_sync1;
    logic            jmp_sync2;
    logic            jmp_sync3;
    logic            jmp_level;
    logic            ack;
    logic [31:0]     rdata;
    logic [1:0]      latch;
    logic [11:0]     in_led;
    logic [1:0]      rdy_led;
    logic [1:0]      pwr_led;
    logic [1:0]      seal_led;
    logic            sel_led;
    logic            tx_led;
    logic            rx_led;
    logic            wd_led;
    logic [WCW-1:0]  wd_cnt;
    logic            nmi;
  } state_t;

  state_t state_reg;
  state_t state_next;

  logic [valve_io_pkg::F_WIDTH-1:0] raw_in;
  logic [valve_io_pkg::F_WIDTH-1:0] filt;
  logic [10:0]                      field_f;
  logic [1:0]                       ready_f;
  logic [1:0]                       power_f;
  logic [1:0]                       sealv_f;
  logic [1:0]                       switch_f;
  logic [2:0]                       excite_f;
  logic [1:0]                       sealin_n;
  logic [valve_io_pkg::HI_WIDTH-1:0] high_image;
  logic                             req;
  logic                             accept;

  assign raw_in = {excite_sense_c_n, excite_sense_b_n, excite_sense_a_n,
                   sealin_switch_b, sealin_switch_a,
                   chan1_sealin_volt_n, chan0_sealin_volt_n,
                   chan1_power_ok_n, chan0_power_ok_n,
                   chan1_ready_n, chan0_ready_n,
                   field_input_n};

  // every field line through the same filter
  pulse_reject_filter #(
    .WIDTH (valve_io_pkg::F_WIDTH),
    .HOLD  (FILTER_CYCLES),
    .INIT  (valve_io_pkg::F_INIT)
  ) u_filter (
    .clk   (clk),
    .nrst  (nrst),
    .raw   (raw_in),
    .clean (filt)
  );

  assign field_f  = filt[valve_io_pkg::F_FIELD +: 11];
  assign ready_f  = filt[valve_io_pkg::F_READY +: 2];
  assign power_f  = filt[valve_io_pkg::F_POWER +: 2];
  assign sealv_f  = filt[valve_io_pkg::F_SEALV +: 2];
  assign switch_f = filt[valve_io_pkg::F_SWITCH +: 2];
  assign excite_f = filt[valve_io_pkg::F_EXCITE +: 3];

  // seal-in status low when switch on and voltage present
  assign sealin_n = ~(switch_f & ~sealv_f);

  assign high_image = {sealin_n, power_f, ready_f, field_f[10:8]};

  assign req    = read | write;
  assign accept = req & state_reg.ack;

  always_comb
  begin
    state_next        = state_reg;
    state_next.jmp_sync1 = calib_jumper;
    state_next.jmp_sync2 = state_reg.jmp_sync1;
    state_next.jmp_sync3 = state_reg.jmp_sync2;
    if (state_reg.jmp_sync2 == state_reg.jmp_sync3)
    begin
      state_next.jmp_level = state_reg.jmp_sync3;
    end

    state_next.nmi = ~state_reg.jmp_level;

    // one wait cycle then answer
    state_next.ack = req & ~state_reg.ack;

    if (req && !state_reg.ack)
    begin
      case (address)
        valve_io_pkg::OFS_OUT_LATCH:
        begin
          state_next.rdata = {30'h0, state_reg.latch};
        end
        valve_io_pkg::OFS_IN_LOW:
        begin
          state_next.rdata = {24'h0, field_f[7:0]};
        end
        valve_io_pkg::OFS_IN_HIGH:
        begin
          state_next.rdata = {23'h0, high_image};
        end
        valve_io_pkg::OFS_EXCITE:
        begin
          state_next.rdata = {29'h0, excite_f};
        end
        valve_io_pkg::OFS_STATUS:
        begin
          state_next.rdata = {30'h0, state_reg.jmp_level, state_reg.nmi};
        end
        default:
        begin
          state_next.rdata = 32'h0;
        end
      endcase
    end

    if (accept && write && byteenable[0] && address == valve_io_pkg::OFS_OUT_LATCH)
    begin
      state_next.latch = writedata[1:0];
    end

    state_next.in_led = {1'b0, ~field_f};

    // ready LED needs power, output off, coil
    state_next.rdy_led = ~power_f & ~state_reg.latch & ~ready_f;

    state_next.pwr_led = ~power_f;

    state_next.seal_led = ~sealin_n;

    state_next.sel_led = rx_select_port_a;

    state_next.tx_led = intercomm_tx_busy;
    state_next.rx_led = intercomm_rx_busy;

    // watchdog LED stretched after each kick
    if (watchdog_kick)
    begin
      state_next.wd_cnt = WCW'(WDOG_CYCLES);
    end
    else if (state_reg.wd_cnt != '0)
    begin
      state_next.wd_cnt = state_reg.wd_cnt - 1'b1;
    end
    state_next.wd_led = (state_next.wd_cnt != '0);
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg        <= '0;
      state_reg.jmp_sync1 <= 1'b1;
      state_reg.jmp_sync2 <= 1'b1;
      state_reg.jmp_sync3 <= 1'b1;
      state_reg.jmp_level <= 1'b1;
      state_reg.latch  <= valve_io_pkg::OUT_RESET;
    end
    else
    begin
      state_reg <= state_next;
    end
  end

  assign waitrequest            = req & ~state_reg.ack;
  assign readdata               = state_reg.rdata;
  assign relay_enable           = state_reg.latch;
  assign chan_out_led           = state_reg.latch;
  assign nmi                    = state_reg.nmi;
  assign serial_port_select_led = state_reg.sel_led;
  assign tx_led                 = state_reg.tx_led;
  assign rx_led                 = state_reg.rx_led;
  assign watchdog_kick_led      = state_reg.wd_led;
  assign chan_ready_led         = state_reg.rdy_led;
  assign power_led              = state_reg.pwr_led;
  assign sealin_led             = state_reg.seal_led;
  assign input_led              = state_reg.in_led;

  // checks
  sequence s_wait;
    req && waitrequest;
  endsequence

  sequence s_latch_wr;
    write && !waitrequest && byteenable[0] && address == valve_io_pkg::OFS_OUT_LATCH;
  endsequence

  sequence s_rd_first(logic [4:0] ofs);
    read && waitrequest && address == ofs;
  endsequence

  a_bus_answer : assert property (@(posedge clk) disable iff (!nrst)
    s_wait |=> !waitrequest)
    else $error("bus request not answered in one cycle");

  a_latch_relay : assert property (@(posedge clk) disable iff (!nrst)
    s_latch_wr |=> relay_enable == $past(writedata[1:0]) && chan_out_led == relay_enable)
    else $error("relay does not follow latch write");

  a_latch_hold : assert property (@(posedge clk) disable iff (!nrst)
    !(write && !waitrequest) |=> relay_enable == $past(relay_enable))
    else $error("latch changed without a write");

  a_low_read : assert property (@(posedge clk) disable iff (!nrst)
    s_rd_first(valve_io_pkg::OFS_IN_LOW) |=> readdata == {24'h0, $past(field_f[7:0])})
    else $error("low input byte wrong");

  a_high_read : assert property (@(posedge clk) disable iff (!nrst)
    s_rd_first(valve_io_pkg::OFS_IN_HIGH) |=> readdata == {23'h0, $past(high_image)})
    else $error("high input byte wrong");

  a_excite_read : assert property (@(posedge clk) disable iff (!nrst)
    s_rd_first(valve_io_pkg::OFS_EXCITE) |=> readdata == {29'h0, $past(excite_f)})
    else $error("excitation sense read wrong");

  a_input_led : assert property (@(posedge clk) disable iff (!nrst)
    ##1 input_led[11] == 1'b0 && input_led[10:0] == ~$past(field_f))
    else $error("input LED does not match status");

  a_ready_led : assert property (@(posedge clk) disable iff (!nrst)
    relay_enable[0] |=> !chan_ready_led[0])
    else $error("ready LED lit while channel energized");

  a_power_led : assert property (@(posedge clk) disable iff (!nrst)
    $fell(power_f[1]) |=> power_led[1])
    else $error("power LED not lit");

  a_sealin_led : assert property (@(posedge clk) disable iff (!nrst)
    !switch_f[0] |=> !sealin_led[0])
    else $error("seal-in LED lit with switch off");

  a_nmi_level : assert property (@(posedge clk) disable iff (!nrst)
    state_reg.jmp_level [*2] |-> !nmi)
    else $error("nmi active with jumper installed");

  a_wdog_led : assert property (@(posedge clk) disable iff (!nrst)
    watchdog_kick |=> watchdog_kick_led [*2])
    else $error("watchdog LED not lit after kick");

  a_select_led : assert property (@(posedge clk) disable iff (!nrst)
    $rose(rx_select_port_a) |=> serial_port_select_led)
    else $error("select LED not lit for port A");

endmodule : valve_io_board_ports

`default_nettype wire

// File: valve_io_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module valve_io_host_model (
  input  wire logic        clk,
  output logic      [4:0]  address,
  output logic             read,
  output logic             write,
  output logic      [3:0]  byteenable,
  output logic      [31:0] writedata,
  input  wire logic [31:0] readdata,
  input  wire logic        waitrequest
);
  initial
  begin
    address = 5'h00;
    read = 1'b0;
    write = 1'b0;
    byteenable = 4'h0;
    writedata = 32'h0;
  end

  // one select per access, whole image in one write
  task automatic bus_access(input logic [4:0] a, input logic wr, input logic [31:0] wd,
                            input logic [3:0] be, output logic [31:0] rdata);
    @(posedge clk);
    address <= a;
    read <= ~wr;
    write <= wr;
    byteenable <= be;
    writedata <= wd;
    // wait for the answer however long it takes; only the bench watchdog ends a hang
    do
    begin
      @(posedge clk);
    end
    while (waitrequest !== 1'b0);
    rdata = readdata;
    read <= 1'b0;
    write <= 1'b0;
    writedata <= ~wd;
  endtask : bus_access
endmodule : valve_io_host_model

`default_nettype wire

// File: valve_io_board_ports_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module valve_io_board_ports_tb_top;
  logic        clk, nrst, read, write, waitrequest, jumper, kick, nmi;
  logic        sel_led, tx_led, rx_led, wd_led;
  logic [4:0]  address;
  logic [3:0]  byteenable;
  logic [31:0] writedata, readdata;
  logic [10:0] field_input_n;
  logic [1:0]  ready_n, power_n, sealv_n, sw, relay_enable;
  logic [1:0]  ready_led, power_led, sealin_led, out_led;
  logic [2:0]  excite_n, link;
  logic [11:0] input_led;
  int          fail_count;
  int          comparisons;

  valve_io_board_ports #(.FILTER_CYCLES(8), .WDOG_CYCLES(5)) i_dut (
    .clk(clk), .nrst(nrst), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .field_input_n(field_input_n),
    .chan0_ready_n(ready_n[0]), .chan1_ready_n(ready_n[1]),
    .chan0_power_ok_n(power_n[0]), .chan1_power_ok_n(power_n[1]),
    .chan0_sealin_volt_n(sealv_n[0]), .chan1_sealin_volt_n(sealv_n[1]),
    .sealin_switch_a(sw[0]), .sealin_switch_b(sw[1]),
    .excite_sense_a_n(excite_n[0]), .excite_sense_b_n(excite_n[1]),
    .excite_sense_c_n(excite_n[2]), .calib_jumper(jumper),
    .rx_select_port_a(link[0]), .intercomm_tx_busy(link[1]),
    .intercomm_rx_busy(link[2]), .watchdog_kick(kick),
    .relay_enable(relay_enable), .nmi(nmi), .serial_port_select_led(sel_led),
    .tx_led(tx_led), .rx_led(rx_led), .watchdog_kick_led(wd_led),
    .chan_ready_led(ready_led), .power_led(power_led), .sealin_led(sealin_led),
    .chan_out_led(out_led), .input_led(input_led)
  );

  valve_io_host_model i_host (
    .clk(clk), .address(address), .read(read), .write(write),
    .byteenable(byteenable), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest)
  );

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check

  task automatic rd(input logic [4:0] a, input logic [31:0] exp);
    logic [31:0] d;
    i_host.bus_access(a, 1'b0, 32'h0, 4'hf, d);
    check(d, exp);
  endtask : rd

  task automatic wr(input logic [4:0] a, input logic [31:0] v, input logic [3:0] be);
    logic [31:0] d;
    i_host.bus_access(a, 1'b1, v, be, d);
    @(negedge clk);
  endtask : wr

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask : settle

  task automatic test_latch();
    for (int i = 0; i < 4; i++)
    begin
      wr(5'h00, 32'(i), 4'h1);
      check({relay_enable, out_led}, {2'(i), 2'(i)});
      rd(5'h00, 32'(i));
    end
    wr(5'h00, 32'h0, 4'he);
    check(relay_enable, 2'h3);
    wr(5'h00, 32'h0, 4'h1);
    $display("test latch done");
  endtask : test_latch

  task automatic test_unmapped();
    rd(5'h14, 32'h0);
    wr(5'h14, 32'h3, 4'hf);
    wr(5'h04, 32'h3, 4'hf);
    check(relay_enable, 2'h0);
    rd(5'h04, 32'hff);
    $display("test unmapped done");
  endtask : test_unmapped

  task automatic test_inputs();
    @(posedge clk);
    field_input_n <= 11'h5a3;
    ready_n <= 2'b10;
    power_n <= 2'b00;
    sealv_n <= 2'b00;
    sw <= 2'b01;
    excite_n <= 3'b010;
    settle(20);
    check(input_led, {1'b0, ~11'h5a3});
    rd(5'h04, 32'h0a3);
    rd(5'h08, 32'h115);
    rd(5'h0c, 32'h2);
    check({ready_led, power_led, sealin_led}, 6'b01_11_01);
    wr(5'h00, 32'h1, 4'h1);
    settle(2);
    check({ready_led, power_led}, 4'b00_11);
    wr(5'h00, 32'h0, 4'h1);
    $display("test inputs done");
  endtask : test_inputs

  task automatic test_glitch();
    @(posedge clk);
    field_input_n[0] <= 1'b0;
    repeat (4) @(posedge clk);
    field_input_n[0] <= 1'b1;
    settle(20);
    check(input_led[0], 1'b0);
    @(posedge clk);
    field_input_n[0] <= 1'b0;
    settle(20);
    check(input_led[0], 1'b1);
    $display("test glitch done");
  endtask : test_glitch

  task automatic test_jumper();
    @(posedge clk);
    jumper <= 1'b0;
    settle(8);
    check(nmi, 1'b1);
    rd(5'h10, 32'h1);
    @(posedge clk);
    jumper <= 1'b1;
    settle(8);
    check(nmi, 1'b0);
    $display("test jumper done");
  endtask : test_jumper

  task automatic test_leds();
    @(posedge clk);
    link <= 3'b011;
    settle(3);
    check({rx_led, tx_led, sel_led}, 3'b011);
    @(posedge clk);
    link <= 3'b100;
    settle(3);
    check({rx_led, tx_led, sel_led}, 3'b100);
    @(posedge clk);
    kick <= 1'b1;
    @(posedge clk);
    kick <= 1'b0;
    settle(2);
    check(wd_led, 1'b1);
    settle(10);
    check(wd_led, 1'b0);
    $display("test leds done");
  endtask : test_leds

  task automatic test_reset();
    wr(5'h00, 32'h3, 4'h1);
    check(relay_enable, 2'h3);
    @(posedge clk);
    nrst <= 1'b0;
    settle(2);
    check({relay_enable, out_led}, 4'h0);
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    rd(5'h00, 32'h0);
    settle(20);
    check(input_led[0], 1'b1);
    $display("test reset mid-run done");
  endtask : test_reset

  task automatic stop_test();
    $display("comparisons %0d fail_count %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : stop_test

  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  initial
  begin
    #2_000_000;
    fail_count++;
    stop_test();
  end

  initial
  begin
    fail_count = 0;
    comparisons = 0;
    nrst = 1'b0;
    field_input_n = 11'h7ff;
    ready_n = 2'b11;
    power_n = 2'b11;
    sealv_n = 2'b11;
    sw = 2'b00;
    excite_n = 3'b111;
    jumper = 1'b1;
    link = 3'b000;
    kick = 1'b0;
    repeat (5) @(posedge clk);
    nrst <= 1'b1;
    settle(10);
    check({relay_enable, nmi, input_led}, 15'h0);
    rd(5'h00, 32'h0);
    $display("test reset done");
    test_latch();
    test_unmapped();
    test_inputs();
    test_glitch();
    test_jumper();
    test_leds();
    test_reset();
    stop_test();
  end
endmodule : valve_io_board_ports_tb_top

`default_nettype wire
